// file: core/sbc_pkg.sv
// shared constants and types for the signed byte sum comparator
package sbc_pkg;
    localparam int ARG_W = 8;
    localparam int MAG_W = 7;
    localparam int SIGN_BIT = 7;
    localparam int SUM_W = 9;
    localparam logic [6:0] MAG_MAX = 7'h7F;
    localparam logic [0:0] SEL_DIFF = 1'h0;
    localparam logic [0:0] SEL_SUM = 1'h1;
    localparam logic [0:0] DIR_OVER = 1'h0;
    localparam logic [0:0] DIR_UNDER = 1'h1;
    localparam logic [0:0] MODE_SIGNED = 1'h0;
    localparam logic [0:0] MODE_ABS = 1'h1;
    localparam int SCALE_W = 16;
    localparam int THR_W = 26;
    localparam int DLY_W = 24;
    localparam real CLK_MHZ = 25.0;
    typedef enum logic [1:0] {
        SBC_IDLE = 2'h0,
        SBC_TIMING = 2'h1,
        SBC_OPERATED = 2'h3,
        SBC_RELEASING = 2'h2
    } sbc_state_t;
endpackage

// file: core/sbc_signmag.sv
// sign-magnitude byte decoder into two's complement
`timescale 1ns/1ns
`default_nettype none
module sbc_signmag (
    input wire logic [7:0] i_bits,
    output logic signed [8:0] o_value
);
    logic [8:0] mag9;
    // bit 7 is the sign, bits 6..0 magnitude lsb first; see RULE_01 RULE_02
    always_comb
    begin
        mag9 = {2'h0, i_bits[sbc_pkg::MAG_W-1:0]};
        if (i_bits[sbc_pkg::SIGN_BIT])
        begin
            o_value = -$signed(mag9);
        end
        else
        begin
            o_value = $signed(mag9);
        end
    end
endmodule // sbc_signmag
`default_nettype wire

// file: core/sbc_top.sv
// signed byte sum comparator with hysteresis and delays
// Functional notes
// RULE_01: first argument bits 0..6 magnitude lsb first, bit 7 negative sign.
// RULE_02: second argument uses the same sign-magnitude layout.
// RULE_03: select low gives first minus second, high gives the sum.
// RULE_04: add or subtract switches at once, no extra delay cycles.
// RULE_05: signed or absolute mode applies to the combined value only.
// RULE_06: result value and result bits come from signed combined value.
// RULE_07: direction picks operate above threshold or below threshold.
// RULE_08: release level is threshold minus hysteresis over, plus under.
// RULE_09: threshold compared against combined value times scale factor.
// RULE_10: one scale factor for both argument values and the result.
// RULE_11: operate asserts after condition held for the assert delay.
// RULE_12: operate releases after release condition held for release delay.
// RULE_13: inhibit clears timers, pickup, operate, logs a blocked event.
// RULE_14: after inhibit ends, resume at once and time from unblocking.
// RULE_15: sources change all eight bits together or delays are used.
// RULE_16: non-negative sources may tie the sign bit to logic zero.
// RULE_17: producers map full scale to a magnitude count of 127.
// RULE_18: pickup asserts when condition met, drops at release condition.
// RULE_19: wide combined value; result bits saturate at magnitude 127.
// RULE_20: delays are counted in block clock cycles, configurable counts.
`timescale 1ns/1ns
`default_nettype none
module sbc_top #(
    parameter int SCALE_W = sbc_pkg::SCALE_W,
    parameter int THR_W = sbc_pkg::THR_W,
    parameter int DLY_W = sbc_pkg::DLY_W
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_first_argument_bits,
    input wire logic [7:0] i_second_argument_bits,
    input wire logic i_sum_or_difference_select,
    input wire logic i_signed_or_absolute_select,
    input wire logic i_compare_direction,
    input wire logic signed [THR_W-1:0] i_trip_threshold,
    input wire logic [THR_W-2:0] i_threshold_hysteresis,
    input wire logic [SCALE_W-1:0] i_value_scale,
    input wire logic [DLY_W-1:0] i_assert_delay,
    input wire logic [DLY_W-1:0] i_release_delay,
    input wire logic i_inhibit_input,
    input wire logic i_event_enable,
    output logic o_operate_flag,
    output logic o_pickup_flag,
    output logic o_blocked_event,
    output logic signed [THR_W-1:0] o_combined_result_value,
    output logic signed [THR_W-1:0] o_scaled_first_value,
    output logic signed [THR_W-1:0] o_scaled_second_value,
    output logic [7:0] o_result_bits
);
    localparam int PROD_W = sbc_pkg::SUM_W + SCALE_W + 1;

    // refuse widths that cannot hold the scaled product or a delay count
    if (THR_W < PROD_W || DLY_W < 1)
    begin : g_width_check
        $error("sbc_top: threshold width too small for scaled value");
    end

    typedef struct packed {
        sbc_pkg::sbc_state_t state;
        logic [DLY_W-1:0] count;
        logic operate;
        logic pickup;
        logic blocked;
        logic inhibit_seen;
        logic signed [THR_W-1:0] res_val;
        logic signed [THR_W-1:0] a_val;
        logic signed [THR_W-1:0] b_val;
        logic [7:0] res_bits;
    } sbc_regs_t;

    sbc_regs_t cur_ff;
    sbc_regs_t nxt_cur;

    logic signed [8:0] a_dec;
    logic signed [8:0] b_dec;

    sbc_signmag u_dec_a (
        .i_bits(i_first_argument_bits),
        .o_value(a_dec)
    );

    sbc_signmag u_dec_b (
        .i_bits(i_second_argument_bits),
        .o_value(b_dec)
    );

    logic signed [9:0] comb_val;
    logic signed [9:0] op_val;
    logic [9:0] comb_mag;
    logic signed [THR_W-1:0] scale_s;
    logic signed [THR_W-1:0] op_scaled;
    logic signed [THR_W-1:0] comb_scaled;
    logic signed [THR_W-1:0] a_scaled;
    logic signed [THR_W-1:0] b_scaled;
    logic signed [THR_W-1:0] drop_level;
    logic cond_met;
    logic drop_met;
    logic [7:0] res_bits;

    always_comb
    begin
        // ten bits cannot overflow for sums of two 7-bit magnitudes
        if (i_sum_or_difference_select == sbc_pkg::SEL_SUM)
        begin
            comb_val = 10'(a_dec) + 10'(b_dec); // see RULE_03 RULE_04 RULE_19
        end
        else
        begin
            comb_val = 10'(a_dec) - 10'(b_dec); // see RULE_03 RULE_04
        end
        if (comb_val < 0)
        begin
            comb_mag = 10'(-comb_val);
        end
        else
        begin
            comb_mag = 10'(comb_val);
        end
        // absolute mode touches only the combined value; see RULE_05
        if (i_signed_or_absolute_select == sbc_pkg::MODE_ABS)
        begin
            op_val = $signed(comb_mag);
        end
        else
        begin
            op_val = comb_val;
        end
        scale_s = $signed({{(THR_W-SCALE_W){1'b0}}, i_value_scale});
        op_scaled = THR_W'(THR_W'(op_val) * scale_s); // see RULE_09
        comb_scaled = THR_W'(THR_W'(comb_val) * scale_s); // see RULE_10
        a_scaled = THR_W'(THR_W'(a_dec) * scale_s); // see RULE_10
        b_scaled = THR_W'(THR_W'(b_dec) * scale_s); // see RULE_10
        // release level widens the band by the hysteresis; see RULE_08
        if (i_compare_direction == sbc_pkg::DIR_OVER)
        begin
            drop_level = i_trip_threshold
                - $signed({1'b0, i_threshold_hysteresis});
            cond_met = op_scaled > i_trip_threshold; // see RULE_07
            drop_met = op_scaled < drop_level;
        end
        else
        begin
            drop_level = i_trip_threshold
                + $signed({1'b0, i_threshold_hysteresis});
            cond_met = op_scaled < i_trip_threshold; // see RULE_07
            drop_met = op_scaled > drop_level;
        end
        // result bits from the signed value, saturated; see RULE_06 RULE_19
        res_bits[sbc_pkg::SIGN_BIT] = comb_val < 0;
        if (comb_mag > 10'(sbc_pkg::MAG_MAX))
        begin
            res_bits[sbc_pkg::MAG_W-1:0] = sbc_pkg::MAG_MAX;
        end
        else
        begin
            res_bits[sbc_pkg::MAG_W-1:0] = comb_mag[sbc_pkg::MAG_W-1:0];
        end
    end

    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_cur.res_val = comb_scaled;
        nxt_cur.a_val = a_scaled;
        nxt_cur.b_val = b_scaled;
        nxt_cur.res_bits = res_bits;
        nxt_cur.inhibit_seen = i_inhibit_input;
        nxt_cur.blocked = 1'b0;
        if (i_inhibit_input)
        begin
            // one event pulse at the start of each inhibit; see RULE_13
            nxt_cur.blocked = i_event_enable && !cur_ff.inhibit_seen;
            nxt_cur.state = sbc_pkg::SBC_IDLE;
            nxt_cur.count = '0;
            nxt_cur.operate = 1'b0;
            nxt_cur.pickup = 1'b0;
        end
        else
        begin
            // idle re-evaluates every cycle, so unblocking times at once
            case (cur_ff.state)
                sbc_pkg::SBC_IDLE:
                begin
                    if (cond_met) // see RULE_14 RULE_18
                    begin
                        nxt_cur.pickup = 1'b1;
                        if (i_assert_delay <= DLY_W'(1))
                        begin
                            nxt_cur.operate = 1'b1; // see RULE_11
                            nxt_cur.state = sbc_pkg::SBC_OPERATED;
                        end
                        else
                        begin
                            nxt_cur.count = DLY_W'(1);
                            nxt_cur.state = sbc_pkg::SBC_TIMING;
                        end
                    end
                end
                sbc_pkg::SBC_TIMING:
                begin
                    if (drop_met)
                    begin
                        nxt_cur.pickup = 1'b0; // see RULE_18
                        nxt_cur.count = '0;
                        nxt_cur.state = sbc_pkg::SBC_IDLE;
                    end
                    else if (!cond_met)
                    begin
                        // inside the band: hold pickup, restart the timer
                        nxt_cur.count = '0;
                    end
                    else if (cur_ff.count + DLY_W'(1) >= i_assert_delay)
                    begin
                        nxt_cur.operate = 1'b1; // see RULE_11 RULE_20
                        nxt_cur.count = '0;
                        nxt_cur.state = sbc_pkg::SBC_OPERATED;
                    end
                    else
                    begin
                        nxt_cur.count = cur_ff.count + DLY_W'(1);
                    end
                end
                sbc_pkg::SBC_OPERATED:
                begin
                    if (drop_met)
                    begin
                        nxt_cur.pickup = 1'b0; // see RULE_18
                        if (i_release_delay <= DLY_W'(1))
                        begin
                            nxt_cur.operate = 1'b0; // see RULE_12
                            nxt_cur.state = sbc_pkg::SBC_IDLE;
                        end
                        else
                        begin
                            nxt_cur.count = DLY_W'(1);
                            nxt_cur.state = sbc_pkg::SBC_RELEASING;
                        end
                    end
                    else if (cond_met)
                    begin
                        // inside the band pickup holds; only the condition raises it
                        nxt_cur.pickup = 1'b1; // see RULE_18
                    end
                end
                sbc_pkg::SBC_RELEASING:
                begin
                    if (!drop_met)
                    begin
                        // release not held continuously: back to operated
                        nxt_cur.count = '0;
                        nxt_cur.pickup = cond_met;
                        nxt_cur.state = sbc_pkg::SBC_OPERATED;
                    end
                    else if (cur_ff.count + DLY_W'(1) >= i_release_delay)
                    begin
                        nxt_cur.operate = 1'b0; // see RULE_12 RULE_20
                        nxt_cur.count = '0;
                        nxt_cur.state = sbc_pkg::SBC_IDLE;
                    end
                    else
                    begin
                        nxt_cur.count = cur_ff.count + DLY_W'(1);
                    end
                end
                default:
                begin
                    nxt_cur.state = sbc_pkg::SBC_IDLE;
                    nxt_cur.count = '0;
                    nxt_cur.operate = 1'b0;
                    nxt_cur.pickup = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cur_ff <= '0;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    assign o_operate_flag = cur_ff.operate;
    assign o_pickup_flag = cur_ff.pickup;
    assign o_blocked_event = cur_ff.blocked;
    assign o_combined_result_value = cur_ff.res_val;
    assign o_scaled_first_value = cur_ff.a_val;
    assign o_scaled_second_value = cur_ff.b_val;
    assign o_result_bits = cur_ff.res_bits;
endmodule // sbc_top
`default_nettype wire

// file: tb/sbc_props.sv
// concurrent checks on the comparator top ports
`timescale 1ns/1ns
`default_nettype none
module sbc_props #(
    parameter int SCALE_W = 16,
    parameter int THR_W = 26,
    parameter int DLY_W = 24
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_first_argument_bits,
    input wire logic [7:0] i_second_argument_bits,
    input wire logic i_sum_or_difference_select,
    input wire logic i_signed_or_absolute_select,
    input wire logic i_compare_direction,
    input wire logic signed [THR_W-1:0] i_trip_threshold,
    input wire logic [THR_W-2:0] i_threshold_hysteresis,
    input wire logic [SCALE_W-1:0] i_value_scale,
    input wire logic [DLY_W-1:0] i_assert_delay,
    input wire logic [DLY_W-1:0] i_release_delay,
    input wire logic i_inhibit_input,
    input wire logic i_event_enable,
    input wire logic o_operate_flag,
    input wire logic o_pickup_flag,
    input wire logic o_blocked_event,
    input wire logic signed [THR_W-1:0] o_combined_result_value,
    input wire logic signed [THR_W-1:0] o_scaled_first_value,
    input wire logic signed [THR_W-1:0] o_scaled_second_value,
    input wire logic [7:0] o_result_bits
);
    logic signed [8:0] a_w, b_w, c_w, m_w;
    logic signed [THR_W-1:0] sa_w, sb_w, sc_w, v_w;
    logic signed [THR_W:0] lo_w, hi_w;
    logic [7:0] rb_w;
    logic met_w, rel_w;

    function automatic logic signed [8:0] dec(input logic [7:0] b);
        return b[7] ? -$signed({2'h0, b[6:0]}) : $signed({2'h0, b[6:0]});
    endfunction

    always_comb
    begin
        a_w = dec(i_first_argument_bits);
        b_w = dec(i_second_argument_bits);
        c_w = i_sum_or_difference_select ? a_w + b_w : a_w - b_w;
        m_w = c_w[8] ? -c_w : c_w;
        sa_w = a_w * $signed({1'b0, i_value_scale});
        sb_w = b_w * $signed({1'b0, i_value_scale});
        sc_w = c_w * $signed({1'b0, i_value_scale});
        v_w = (i_signed_or_absolute_select && sc_w < 0) ? -sc_w : sc_w;
        rb_w = {c_w[8], m_w > 9'sh07F ? sbc_pkg::MAG_MAX : m_w[6:0]};
        hi_w = i_trip_threshold + $signed({2'h0, i_threshold_hysteresis});
        lo_w = i_trip_threshold - $signed({2'h0, i_threshold_hysteresis});
        met_w = i_compare_direction ? v_w < i_trip_threshold
            : v_w > i_trip_threshold;
        rel_w = i_compare_direction ? v_w > hi_w : v_w < lo_w;
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_inhibit_held;
        i_inhibit_input ##1 i_inhibit_input;
    endsequence

    chk_scaled_args: assert property (
        $past(i_reset_n) |-> o_scaled_first_value == $past(sa_w)
            && o_scaled_second_value == $past(sb_w))
        else $error("scaled argument wrong");
    chk_combined_value: assert property (
        $past(i_reset_n) |-> o_combined_result_value == $past(sc_w))
        else $error("combined value wrong");
    chk_result_bits: assert property (
        $past(i_reset_n) |-> o_result_bits == $past(rb_w))
        else $error("result bits wrong");
    chk_inhibit_clears: assert property (
        i_inhibit_input |=> !o_pickup_flag && !o_operate_flag)
        else $error("flags kept while inhibited");
    chk_event_cause: assert property (
        o_blocked_event |-> $past(i_inhibit_input) && $past(i_event_enable))
        else $error("blocked event without cause");
    chk_event_once: assert property (
        s_inhibit_held |=> !o_blocked_event)
        else $error("blocked event repeated");
    chk_pickup_cause: assert property (
        $rose(o_pickup_flag) |-> $past(met_w) && !$past(i_inhibit_input))
        else $error("pickup without condition");
    chk_pickup_drop: assert property (
        rel_w |=> !o_pickup_flag)
        else $error("pickup held in release zone");
    chk_operate_rise: assert property (
        $rose(o_operate_flag) |-> $past(met_w) && ($past(o_pickup_flag)
            || $past(i_assert_delay) <= 24'h000001))
        else $error("operate rose early");
    chk_operate_fall: assert property (
        $fell(o_operate_flag) |-> $past(rel_w) || $past(i_inhibit_input))
        else $error("operate fell without release");
endmodule // sbc_props

bind sbc_top sbc_props #(.SCALE_W(SCALE_W), .THR_W(THR_W), .DLY_W(DLY_W))
    u_props (.*);
`default_nettype wire

// file: tb/sbc_src_model.sv
// far-side byte source: clamps to full scale, sign-magnitude out
`timescale 1ns/1ns
`default_nettype none
module sbc_src_model (
    input var int i_level,
    input wire logic i_pos_only,
    output logic [7:0] o_bits
);
    int mag;
    always_comb
    begin
        mag = i_level < 0 ? -i_level : i_level;
        mag = mag > 32'sh7F ? 32'sh7F : mag;
        // whole byte recomputed at once, so no mixed bit patterns appear
        o_bits = {~i_pos_only & (i_level < 0), mag[6:0]};
    end
endmodule // sbc_src_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the signed byte sum comparator
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [7:0] i_first_argument_bits, i_second_argument_bits;
    logic i_sum_or_difference_select, i_signed_or_absolute_select;
    logic i_compare_direction, i_inhibit_input, i_event_enable;
    logic signed [25:0] i_trip_threshold;
    logic [24:0] i_threshold_hysteresis;
    logic [15:0] i_value_scale;
    logic [23:0] i_assert_delay, i_release_delay;
    logic o_operate_flag, o_pickup_flag, o_blocked_event;
    logic signed [25:0] o_combined_result_value, o_scaled_first_value;
    logic signed [25:0] o_scaled_second_value;
    logic [7:0] o_result_bits;
    int lvl_a = 0, lvl_b = 0, num_errors = 0, num_checks = 0;
    logic pos_a = 1'b0, pos_b = 1'b0;
    int m_a, m_b, m_c, m_rb, m_pk, m_op, m_ev, cnt, prev_inh;

    always #20 i_clk = ~i_clk;
    sbc_src_model src_a (.i_level(lvl_a), .i_pos_only(pos_a),
        .o_bits(i_first_argument_bits));
    sbc_src_model src_b (.i_level(lvl_b), .i_pos_only(pos_b),
        .o_bits(i_second_argument_bits));
    sbc_top DUT (.*);

    function automatic int dec(input logic [7:0] v);
        return v[7] ? -int'(v[6:0]) : int'(v[6:0]);
    endfunction
    function automatic int lim(input logic [23:0] d);
        return d > 24'h000001 ? int'(d) : 1;
    endfunction

    always @(posedge i_clk or negedge i_reset_n)
    begin : model
        int c, v, thr, hys, met, rel;
        if (!i_reset_n)
            {m_a, m_b, m_c, m_rb, m_pk, m_op, m_ev, cnt, prev_inh} = '0;
        else
        begin
            c = dec(i_first_argument_bits);
            v = dec(i_second_argument_bits);
            m_a = c * int'(i_value_scale);
            m_b = v * int'(i_value_scale);
            c = i_sum_or_difference_select ? c + v : c - v;
            m_c = c * int'(i_value_scale);
            v = c < 0 ? -c : c;
            m_rb = (c < 0 ? 128 : 0) + (v > 127 ? 127 : v);
            v = (i_signed_or_absolute_select && m_c < 0) ? -m_c : m_c;
            thr = int'(i_trip_threshold);
            hys = int'(i_threshold_hysteresis);
            met = i_compare_direction ? v < thr : v > thr;
            rel = i_compare_direction ? v > thr + hys : v < thr - hys;
            m_ev = i_inhibit_input && !prev_inh && i_event_enable;
            prev_inh = i_inhibit_input;
            if (i_inhibit_input)
                {m_pk, m_op, cnt} = '0;
            else if (!m_op && met)
            begin
                m_pk = 1;
                cnt++;
                m_op = cnt >= lim(i_assert_delay);
                cnt = m_op ? 0 : cnt;
            end
            else if (m_op && rel)
            begin
                m_pk = 0;
                cnt++;
                m_op = cnt < lim(i_release_delay);
                cnt = m_op ? cnt : 0;
            end
            else
            begin
                cnt = 0;
                m_pk = rel ? 0 : (met ? 1 : m_pk);
            end
        end
    end

    task automatic cmp_val(input logic signed [25:0] got, input int exp);
        num_checks++;
        if (got !== exp[25:0])
        begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp[25:0]);
        end
    endtask
    task automatic cmp_flag(input logic got, input int exp);
        num_checks++;
        if (got !== exp[0])
        begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp[0]);
        end
    endtask
    task automatic end_of_test;
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(negedge i_clk)
    begin
        if (i_reset_n)
        begin
            cmp_val(o_scaled_first_value, m_a);
            cmp_val(o_scaled_second_value, m_b);
            cmp_val(o_combined_result_value, m_c);
            cmp_val({18'h0, o_result_bits}, m_rb);
            cmp_flag(o_pickup_flag, m_pk);
            cmp_flag(o_operate_flag, m_op);
            cmp_flag(o_blocked_event, m_ev);
        end
    end

    initial
    begin
        #(40 * 6000);
        num_errors++;
        end_of_test();
    end

    initial
    begin
        {i_inhibit_input, i_event_enable, i_compare_direction} = '0;
        {i_sum_or_difference_select, i_signed_or_absolute_select} = '0;
        {i_trip_threshold, i_threshold_hysteresis, i_value_scale} = '0;
        {i_assert_delay, i_release_delay} = '0;
        void'($urandom(77));
        repeat (12) @(negedge i_clk);
        i_reset_n = 1'b1;
        // every direction, mode and add/subtract setting, twice
        for (int k = 0; k < 16; k++)
        begin
            {i_compare_direction, i_signed_or_absolute_select} = 2'(k >> 1);
            i_sum_or_difference_select = k[0];
            i_event_enable = k[3];
            pos_a = k[3];
            pos_b = k[2];
            i_value_scale = 16'($urandom_range(1, 40));
            i_trip_threshold = 26'(int'($urandom_range(0, 6000)) - 3000);
            i_threshold_hysteresis = 25'($urandom_range(0, 300));
            i_assert_delay = 24'($urandom_range(0, 8));
            i_release_delay = 24'($urandom_range(0, 8));
            repeat (250)
            begin
                @(negedge i_clk);
                if ($urandom_range(0, 5) == 0)
                    lvl_a = int'($urandom_range(0, 340)) - 170;
                if ($urandom_range(0, 5) == 0)
                    lvl_b = int'($urandom_range(0, 340)) - 170;
                if ($urandom_range(0, 30) == 0)
                    i_sum_or_difference_select = ~i_sum_or_difference_select;
                if ($urandom_range(0, 40) == 0)
                    i_inhibit_input = ~i_inhibit_input;
            end
            if (k == 9)
            begin
                i_reset_n = 1'b0;
                repeat (2) @(negedge i_clk);
                i_reset_n = 1'b1;
            end
        end
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
